/* rtl/vec_pkg.sv */
// Purpose: Shared constants and types of the vector adder/subtracter.
// Assumes: Fixed-point operands, four lanes of 16 bits each.
// Notes:   Register words are 32 bits; reserved bits read as zero.

package vec_pkg;

    // -------------------------------------------------------------
    // Datapath geometry.
    // -------------------------------------------------------------
    localparam int LANES        = 4;   // parallel_lane_count.
    localparam int IN_W         = 16;
    localparam int RAW_W        = 18;  // Exact sum or difference.
    localparam int OUT_W        = 17;  // Full-precision result width.
    localparam int EXT_W        = 34;  // Room for alignment shifts.
    localparam int MAX_LAT      = 8;
    localparam int CORE_MAX_LAT = 2;
    localparam int FIFO_DEPTH   = 16;
    localparam int LAT_W        = 4;
    localparam int DIV_W        = 8;

    // -------------------------------------------------------------
    // Register map.
    // -------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FMT  = 8'h04;
    localparam logic [7:0] OFS_TIM  = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0C;
    localparam int STAT_OVF_BIT     = 8;

    typedef enum logic [1:0] {OP_ADD, OP_SUB, OP_SEL} op_t;
    typedef enum logic [1:0] {Q_TRUNC, Q_ROUND_INF, Q_ROUND_EVEN} quant_t;

    typedef struct packed {
        logic [20:0] rsvd;
        logic        carry_out_en;
        logic        carry_in_en;
        logic        max_pipe;
        quant_t      quant;
        logic        ovf_sat;
        logic        out_signed;
        logic        in_signed;
        logic        user_prec;
        op_t         op;
    } ctrl_t;

    typedef struct packed {
        logic [16:0] rsvd;
        logic [4:0]  out_bp;
        logic [4:0]  out_w;
        logic [4:0]  in_bp;
    } fmt_t;

    typedef struct packed {
        logic [19:0]      rsvd;
        logic [DIV_W-1:0] div;
        logic [LAT_W-1:0] lat;
    } tim_t;

    localparam ctrl_t CTRL_RST = '{op: OP_ADD, quant: Q_TRUNC, default: '0};
    localparam fmt_t  FMT_RST  = '{rsvd: '0, out_bp: 5'h08, out_w: 5'h11, in_bp: 5'h08};
    localparam tim_t  TIM_RST  = '{rsvd: '0, div: 8'h00, lat: 4'h1};

    // -------------------------------------------------------------
    // Stream carriers.
    // -------------------------------------------------------------
    typedef struct packed {
        logic [LANES-1:0][IN_W-1:0] a;
        logic [LANES-1:0][IN_W-1:0] b;
        logic                       minus_select;
        logic                       carry_input;
    } in_t;

    typedef struct packed {
        logic [LANES-1:0][OUT_W-1:0] sum;
        logic [LANES-1:0]            carry_output;
    } out_t;

    typedef struct packed {
        logic valid;
        logic ovf;
        out_t data;
    } slot_t;

    typedef struct packed {
        logic                        valid;
        logic [LANES-1:0][RAW_W-1:0] raw;
    } stage_t;

endpackage

/* rtl/sync_fifo.sv */
// Purpose: Flip-flop FIFO with valid/ready on both sides.
// Assumes: DEPTH is a power of two.
// Notes:   Read data comes straight from the storage flops.

`timescale 1ns/1ps

module sync_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset.
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // Fill side.
    input  wire logic                   in_valid_i,
    output logic                        in_ready_o,
    input  wire logic [W-1:0]           in_data_i,
    // Drain side.
    output logic                        out_valid_o,
    input  wire logic                   out_ready_i,
    output logic [W-1:0]                out_data_o,
    output logic [$clog2(DEPTH):0]      count_o
);

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW:0]             wp;
        logic [AW:0]             rp;
    } st_t;

    st_t         s_q;
    st_t         s_d;
    logic [AW:0] cnt;
    logic        wr;
    logic        rd;

    // Extra pointer bit tells full from empty without a separate flag.
    assign cnt         = s_q.wp - s_q.rp;
    assign in_ready_o  = (cnt != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt != '0);
    assign wr          = in_valid_i && in_ready_o;
    assign rd          = out_valid_o && out_ready_i;
    assign out_data_o  = s_q.mem[s_q.rp[AW-1:0]];
    assign count_o     = cnt;

    // Next state: write at the tail, read from the head.
    always_comb begin
        s_d = s_q;
        if (wr) begin
            s_d.mem[s_q.wp[AW-1:0]] = in_data_i;
            s_d.wp = s_q.wp + (AW+1)'(1);
        end
        if (rd) begin
            s_d.rp = s_q.rp + (AW+1)'(1);
        end
    end

    // State register.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule

/* rtl/tap_delay_line.sv */
// Purpose: Shift register with a run-time output tap.
// Assumes: tap_i never exceeds DEPTH.
// Notes:   Tap zero passes the input through with no register.

`timescale 1ns/1ps

module tap_delay_line #(
    parameter int W     = 8,
    parameter int DEPTH = 8,
    localparam int TAP_W = $clog2(DEPTH + 1)
) (
    // Clock and reset.
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Shift control.
    input  wire logic             ce_i,
    input  wire logic [TAP_W-1:0] tap_i,
    // Data.
    input  wire logic [W-1:0]     d_i,
    output logic [W-1:0]          q_o
);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] sr;
    } st_t;

    st_t s_q;
    st_t s_d;

    // Stage i holds the word that entered i+1 advances ago.
    assign q_o = (tap_i == '0) ? d_i : s_q.sr[tap_i - TAP_W'(1)];

    // Shift only on an advance, so a stall freezes every stage.
    always_comb begin
        s_d = s_q;
        if (ce_i) begin
            s_d.sr[0] = d_i;
            for (int i = 1; i < DEPTH; i++) begin
                s_d.sr[i] = s_q.sr[i-1];
            end
        end
    end

    // State register.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule

/* rtl/vector_add_subtract.sv */
// Purpose: Lane-parallel fixed-point adder/subtracter with Wishbone setup.
// Assumes: Operands are fixed-point; one clock; synchronous reset.
// Notes:   Results pass a 16-word FIFO that back-pressures the pipeline.

`timescale 1ns/1ps

// Function
// - Fixed add, fixed subtract, or selectable
// - Select input high means subtract
// - Carry in only user precision, zero point
// - Carry out only unsigned, matching integer bits
// - Result delayed configurable sample periods
// - Unpipelined extra delay is output shift register
// - Pipelined delay spreads into core first
// - Unpipelined core holds exactly one register; at delay zero the code has none and the input passes straight through
// - Full precision result is exact
// - User precision sets sign, width, point
// - Floating operands always give full precision
// - All lanes apply same operation independently
// - Overflow saturates or wraps
// - Fraction reduction truncates or rounds
// - Convergent rounding ties go to even
module vector_add_subtract (
    // Clock and reset.
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    // Wishbone slave.
    input  wire logic [7:0]    wb_adr_i,
    input  wire logic [31:0]   wb_dat_i,
    input  wire logic [3:0]    wb_sel_i,
    input  wire logic          wb_we_i,
    input  wire logic          wb_cyc_i,
    input  wire logic          wb_stb_i,
    output logic [31:0]        wb_dat_o,
    output logic               wb_ack_o,
    // Operand stream.
    input  wire logic          in_valid_i,
    output logic               in_ready_o,
    input  wire vec_pkg::in_t  in_data_i,
    // Result stream.
    output logic               out_valid_o,
    input  wire logic          out_ready_i,
    output vec_pkg::out_t      out_data_o
);

    import vec_pkg::*;

    // -------------------------------------------------------------
    // Arithmetic helpers.
    // -------------------------------------------------------------

    // Widen one operand to the exact-result width.
    function automatic logic [RAW_W-1:0] ext(input logic [IN_W-1:0] x, input logic sgn);
        return {{(RAW_W-IN_W){sgn & x[IN_W-1]}}, x};
    endfunction

    // Exact per-lane result; every lane sees the same operation.
    function automatic logic [LANES-1:0][RAW_W-1:0] lanes_raw(
        input in_t d, input ctrl_t c, input logic cin_ok);
        logic                        sub;
        logic [RAW_W-1:0]            ci;
        logic [LANES-1:0][RAW_W-1:0] r;
        sub = (c.op == OP_SUB) || ((c.op == OP_SEL) && d.minus_select);
        ci  = RAW_W'(d.carry_input & cin_ok);
        for (int i = 0; i < LANES; i++) begin
            r[i] = sub ? ext(d.a[i], c.in_signed) - ext(d.b[i], c.in_signed) + ci
                       : ext(d.a[i], c.in_signed) + ext(d.b[i], c.in_signed) + ci;
        end
        return r;
    endfunction

    // Align, round and range-limit one exact result; bit OUT_W is overflow.
    function automatic logic [OUT_W:0] quantize(
        input logic [RAW_W-1:0] raw, input ctrl_t c, input fmt_t f);
        logic signed [EXT_W-1:0] v;
        logic signed [EXT_W-1:0] q;
        logic signed [EXT_W-1:0] hi;
        logic signed [EXT_W-1:0] lo;
        logic signed [EXT_W-1:0] one;
        logic [4:0]              sh;
        logic                    half;
        logic                    below;
        logic                    up;
        logic                    ovf;
        logic [OUT_W-1:0]        mask;
        one   = EXT_W'(1);
        v     = {{(EXT_W-RAW_W){raw[RAW_W-1]}}, raw};
        half  = 1'b0;
        below = 1'b0;
        sh    = 5'h00;
        if (f.out_bp >= f.in_bp) begin
            q = v <<< (f.out_bp - f.in_bp);
        end else begin
            sh    = f.in_bp - f.out_bp;
            q     = v >>> sh;
            half  = v[sh - 5'h01];
            below = |(v & ((one <<< (sh - 5'h01)) - one));
        end
        // Floor plus a one-LSB step gives each rounding style.
        unique case (c.quant)
            Q_TRUNC:      up = 1'b0;
            Q_ROUND_INF:  up = half & (!v[EXT_W-1] | below);
            Q_ROUND_EVEN: up = half & (below | q[0]);
            default:      up = 1'b0;
        endcase
        q    = q + (up ? one : '0);
        hi   = c.out_signed ? (one <<< (f.out_w - 5'h01)) - one : (one <<< f.out_w) - one;
        lo   = c.out_signed ? -(one <<< (f.out_w - 5'h01)) : '0;
        ovf  = (q > hi) || (q < lo);
        if (ovf && c.ovf_sat) begin
            q = (q > hi) ? hi : lo;
        end
        // Wrap drops everything above the top kept bit.
        mask = OUT_W'((one <<< f.out_w) - one);
        return {ovf, q[OUT_W-1:0] & mask};
    endfunction

    // Turn a set of exact results into one pipeline slot.
    function automatic slot_t lanes_out(input logic v,
        input logic [LANES-1:0][RAW_W-1:0] raw, input ctrl_t c, input fmt_t f,
        input logic cout_ok);
        slot_t          s;
        logic [OUT_W:0] qz;
        s       = '0;
        s.valid = v;
        for (int i = 0; i < LANES; i++) begin
            if (c.user_prec) begin
                qz                  = quantize(raw[i], c, f);
                s.data.sum[i]       = qz[OUT_W-1:0];
                s.ovf               = s.ovf | qz[OUT_W];
                s.data.carry_output[i] = raw[i][IN_W] & cout_ok;
            end else begin
                s.data.sum[i]       = raw[i][OUT_W-1:0];
            end
        end
        return s;
    endfunction

    // Byte-lane write merge.
    function automatic logic [31:0] merge(
        input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        logic [31:0] r;
        for (int i = 0; i < 4; i++) begin
            r[8*i +: 8] = sel[i] ? nw[8*i +: 8] : old[8*i +: 8];
        end
        return r;
    endfunction

    // -------------------------------------------------------------
    // State and wiring.
    // -------------------------------------------------------------
    typedef struct packed {
        ctrl_t            ctrl;
        fmt_t             fmt;
        tim_t             tim;
        logic [DIV_W-1:0] div_cnt;
        logic             ack;
        logic [31:0]      rdat;
        logic             ovf_sticky;
        stage_t           a;
    } st_t;

    localparam st_t ST_RST = '{ctrl: CTRL_RST, fmt: FMT_RST, tim: TIM_RST, div_cnt: '0,
                               ack: 1'b0, rdat: '0, ovf_sticky: 1'b0, a: '0};

    st_t                         s_q;
    st_t                         s_d;
    logic [LAT_W-1:0]            lat_eff;
    logic [LAT_W-1:0]            tap;
    logic                        pipe2;
    logic                        tick;
    logic                        ce;
    logic                        cin_ok;
    logic                        cout_ok;
    logic                        fifo_valid;
    logic                        fifo_ready;
    logic                        push;
    logic [4:0]                  fifo_cnt;
    logic [LANES-1:0][RAW_W-1:0] in_raw;
    slot_t                       dl_in;
    slot_t                       dl_out;

    // Carry ports exist only under their legal formats; otherwise they read as zero.
    assign cin_ok  = s_q.ctrl.carry_in_en && s_q.ctrl.user_prec
                     && (s_q.fmt.in_bp == 5'h00);
    assign cout_ok = s_q.ctrl.carry_out_en && s_q.ctrl.user_prec && !s_q.ctrl.in_signed
                     && !s_q.ctrl.out_signed
                     && ({1'b0, s_q.fmt.out_w} - {1'b0, s_q.fmt.out_bp}
                         == 6'(IN_W) - {1'b0, s_q.fmt.in_bp});

    // Operands are fixed-point only, so full precision is the sole float-safe mode.
    assign in_raw = lanes_raw(in_data_i, s_q.ctrl, cin_ok);

    // Latency split: pipelined mode fills the core first, the rest is tail.
    assign lat_eff = (s_q.tim.lat > LAT_W'(MAX_LAT)) ? LAT_W'(MAX_LAT) : s_q.tim.lat;
    assign pipe2   = s_q.ctrl.max_pipe && (lat_eff >= LAT_W'(CORE_MAX_LAT));
    assign tap     = pipe2 ? lat_eff - 4'h1 : lat_eff;
    // Without pipelining the core register is the delay line's first stage.
    assign dl_in   = pipe2 ? lanes_out(s_q.a.valid, s_q.a.raw, s_q.ctrl, s_q.fmt, cout_ok)
                           : lanes_out(in_valid_i, in_raw, s_q.ctrl, s_q.fmt, cout_ok);

    // One sample period per divider wrap; a full FIFO stalls the whole pipe while a valid result waits at the tap.
    assign tick       = (s_q.div_cnt == '0);
    assign fifo_valid = tick && dl_out.valid;
    assign push       = fifo_valid && fifo_ready;
    assign ce         = tick && (!dl_out.valid || fifo_ready);
    assign in_ready_o = ce;
    assign wb_ack_o   = s_q.ack;
    assign wb_dat_o   = s_q.rdat;

    tap_delay_line #(
        .W     ($bits(slot_t)),
        .DEPTH (MAX_LAT)
    ) u_delay (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i  (ce),
        .tap_i (tap),
        .d_i   (dl_in),
        .q_o   (dl_out)
    );

    sync_fifo #(
        .W     ($bits(out_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (fifo_valid),
        .in_ready_o  (fifo_ready),
        .in_data_i   (dl_out.data),
        .out_valid_o (out_valid_o),
        .out_ready_i (out_ready_i),
        .out_data_o  (out_data_o),
        .count_o     (fifo_cnt)
    );

    // -------------------------------------------------------------
    // Next state: bus slave, divider and core stage.
    // -------------------------------------------------------------
    always_comb begin
        logic ovf_clr;
        ovf_clr = 1'b0;
        s_d     = s_q;
        // Ack one cycle after the request; read data is captured with it.
        s_d.ack = wb_cyc_i && wb_stb_i && !s_q.ack;
        if (s_d.ack) begin
            unique case (wb_adr_i)
                OFS_CTRL: s_d.rdat = s_q.ctrl;
                OFS_FMT:  s_d.rdat = s_q.fmt;
                OFS_TIM:  s_d.rdat = s_q.tim;
                OFS_STAT: s_d.rdat = {23'h000000, s_q.ovf_sticky, 3'h0, fifo_cnt};
                default:  s_d.rdat = 32'h00000000;
            endcase
        end
        // Writes land on the edge where the master sees ack.
        if (wb_cyc_i && wb_stb_i && s_q.ack && wb_we_i) begin
            unique case (wb_adr_i)
                OFS_CTRL: s_d.ctrl = merge(s_q.ctrl, wb_dat_i, wb_sel_i);
                OFS_FMT:  s_d.fmt  = merge(s_q.fmt, wb_dat_i, wb_sel_i);
                OFS_TIM:  s_d.tim  = merge(s_q.tim, wb_dat_i, wb_sel_i);
                OFS_STAT: ovf_clr  = wb_sel_i[1] && wb_dat_i[STAT_OVF_BIT];
                default:  ovf_clr  = 1'b0;
            endcase
            s_d.ctrl.rsvd = '0;
            s_d.fmt.rsvd  = '0;
            s_d.tim.rsvd  = '0;
        end
        // A new overflow beats a clear in the same cycle.
        s_d.ovf_sticky = (s_q.ovf_sticky && !ovf_clr) || (push && dl_out.ovf);
        s_d.div_cnt    = tick ? s_q.tim.div : s_q.div_cnt - 8'h01;
        // Core stage keeps the exact sum, so select and carry stay with their pair.
        if (ce) begin
            s_d.a.valid = in_valid_i;
            s_d.a.raw   = in_raw;
        end
    end

    // State register.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= ST_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // -------------------------------------------------------------
    // Checks.
    // -------------------------------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    localparam ctrl_t CT_EVEN = '{op: OP_ADD, quant: Q_ROUND_EVEN, user_prec: 1'b1,
                                  out_signed: 1'b1, default: '0};
    localparam ctrl_t CT_INF  = '{op: OP_ADD, quant: Q_ROUND_INF, user_prec: 1'b1,
                                  out_signed: 1'b1, default: '0};
    localparam ctrl_t CT_TRNC = '{op: OP_ADD, quant: Q_TRUNC, user_prec: 1'b1,
                                  out_signed: 1'b1, default: '0};
    localparam ctrl_t CT_SAT  = '{op: OP_ADD, quant: Q_TRUNC, user_prec: 1'b1,
                                  ovf_sat: 1'b1, default: '0};
    localparam fmt_t  FT_RND  = '{rsvd: '0, out_bp: 5'h02, out_w: 5'h11, in_bp: 5'h04};
    localparam fmt_t  FT_U8   = '{rsvd: '0, out_bp: 5'h00, out_w: 5'h08, in_bp: 5'h00};

    a_add_fixed: assert property (push && s_q.ctrl.op == OP_ADD && !s_q.ctrl.user_prec
        && lat_eff == 4'h0 |-> dl_out.data.sum[0] == OUT_W'(ext(in_data_i.a[0],
        s_q.ctrl.in_signed) + ext(in_data_i.b[0], s_q.ctrl.in_signed)))
        else $error("Fixed addition gave a wrong lane result.");
    a_sel_minus: assert property (push && s_q.ctrl.op == OP_SEL && !s_q.ctrl.user_prec
        && lat_eff == 4'h0 && in_data_i.minus_select |-> dl_out.data.sum[LANES-1]
        == OUT_W'(ext(in_data_i.a[LANES-1], s_q.ctrl.in_signed)
        - ext(in_data_i.b[LANES-1], s_q.ctrl.in_signed)))
        else $error("Selected subtraction gave a wrong lane result.");
    a_carry_in: assert property (in_valid_i && s_q.ctrl.op == OP_ADD
        && in_data_i.carry_input |-> in_raw[0] == ext(in_data_i.a[0], s_q.ctrl.in_signed)
        + ext(in_data_i.b[0], s_q.ctrl.in_signed) + RAW_W'(cin_ok))
        else $error("Carry in applied while illegal or lost while legal.");
    a_cout_gate: assert property (push && !cout_ok |-> dl_out.data.carry_output == '0)
        else $error("Carry out driven in an illegal format.");
    a_lat_one: assert property (ce && lat_eff == 4'h1 |=> dl_out.valid == $past(in_valid_i))
        else $error("Result with delay one not at the first stage.");
    a_core_fill: assert property (ce && in_valid_i && pipe2 |=> s_q.a.valid ##0
        tap == lat_eff - 4'h1) else $error("Pipelined core stage not loaded.");
    a_sat_wrap: assert property (quantize(18'h0012C, CT_SAT, FT_U8) == 18'h200FF
        && quantize(18'h0012C, CT_TRNC, FT_U8) == 18'h2002C)
        else $error("Saturate or wrap gave a wrong value.");
    a_round_trunc: assert property (quantize(18'h0001A, CT_INF, FT_RND) == 18'h00007
        && quantize(18'h3FFE6, CT_INF, FT_RND) == 18'h1FFF9
        && quantize(18'h3FFE6, CT_TRNC, FT_RND) == 18'h1FFF9)
        else $error("Truncate or symmetric round gave a wrong value.");
    a_conv_even: assert property (quantize(18'h0001A, CT_EVEN, FT_RND) == 18'h00006
        && quantize(18'h00016, CT_EVEN, FT_RND) == 18'h00006
        && quantize(18'h3FFE6, CT_EVEN, FT_RND) == 18'h1FFFA)
        else $error("Convergent rounding did not pick the even value.");

    c_sub_sel: cover property (ce && in_valid_i && s_q.ctrl.op == OP_SEL
        && in_data_i.minus_select);
    c_fifo_full: cover property (tick && dl_out.valid && !fifo_ready);
    c_pipe_deep: cover property (push && pipe2);
    c_sat_hit: cover property (push && dl_out.ovf && s_q.ctrl.ovf_sat);

endmodule

/* sim/vec_sink.sv */
// Purpose: Downstream sink that takes results or stalls on request.
// Assumes: The bench raises stall_i to keep results queued in the FIFO.
// Notes:   Ready is registered, so a stall lands one edge late.
`timescale 1ns/1ps
module vec_sink (
    // Clock, reset and stall request.
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic stall_i,
    // Handshake to the block.
    output logic      ready_o
);
    // Ready stays low in reset so nothing is taken before the bench looks.
    always_ff @(posedge clk_i) begin
        ready_o <= !rst_i && !stall_i;
    end
endmodule

/* sim/vector_add_subtract_tb.sv */
// Purpose: Self-checking bench for the vector adder/subtracter.
// Assumes: Lane i carries a+i, so a lane mix-up shows at once.
// Notes:   The sink stalls while pairs queue, so no result slips by.
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED t=%0t got %h", $time, g); end end
module vector_add_subtract_tb;
    import vec_pkg::*;
    logic        clk_i = 0, rst_i = 1, stall = 1, in_valid_i = 0, we = 0, stb = 0;
    logic        ack, in_ready_o, out_valid_o, rdy;
    logic [7:0]  adr = '0;
    logic [31:0] wdat = '0, rdat, rd;
    in_t         in_data_i = '0;
    out_t        out_data_o;
    int          err_count = 0, samples_checked = 0, cyc = 0, n;
    // Free-running 40 MHz clock.
    always #12.5 clk_i = ~clk_i;
    vector_add_subtract dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(stb), .wb_stb_i(stb),
        .wb_dat_o(rdat), .wb_ack_o(ack), .in_valid_i(in_valid_i), .in_ready_o(in_ready_o),
        .in_data_i(in_data_i), .out_valid_o(out_valid_o), .out_ready_i(rdy),
        .out_data_o(out_data_o));
    vec_sink sink (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall), .ready_o(rdy));
    // One classic cycle; cyc and stb share one driver as they rise and fall together.
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        adr <= a;
        we <= w;
        wdat <= d;
        stb <= 1'b1;
        do @(posedge clk_i); while (ack !== 1'b1);
        rd = rdat;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    // Valid is held on, so the caller lowers it after the last pair.
    task automatic send(input logic [15:0] a, b, input logic ms);
        for (int i = 0; i < LANES; i++) begin
            in_data_i.a[i] <= a + 16'(i);
            in_data_i.b[i] <= b;
        end
        in_data_i.minus_select <= ms;
        in_valid_i <= 1'b1;
        do @(posedge clk_i); while (in_ready_o !== 1'b1);
    endtask
    task automatic get(input logic [15:0] a, b, input logic sub);
        logic [16:0] e;
        do @(posedge clk_i); while (!(out_valid_o === 1'b1 && rdy === 1'b1));
        for (int i = 0; i < LANES; i++) begin
            e = {1'b0, 16'(a + 16'(i))};
            e = sub ? e - {1'b0, b} : e + {1'b0, b};
            `CHK(out_data_o.sum[i], e)
        end
    endtask
    task automatic t_regs;
        wb(OFS_FMT, 1'b0, '0);
        `CHK(rd, 32'h0000_2228)
        wb(OFS_TIM, 1'b0, '0);
        `CHK(rd, 32'h0000_0001)
        wb(8'h10, 1'b0, '0);
        `CHK(rd, 32'h0000_0000)
    endtask
    // Delay zero first, so the fixed-operation checks see the direct core path.
    task automatic t_ops;
        wb(OFS_TIM, 1'b1, 32'h0000_0000);
        for (int op = 0; op < 3; op++) begin
            wb(OFS_CTRL, 1'b1, 32'(op));
            send(16'hFFF0, 16'hFFFF, op == 2);
            in_valid_i <= 1'b0;
            stall <= 1'b0;
            get(16'hFFF0, 16'hFFFF, op != 0);
            stall <= 1'b1;
        end
    endtask
    // Same end-to-end delay is expected with and without internal pipelining.
    task automatic t_lat;
        for (int p = 0; p < 2; p++) begin
            wb(OFS_CTRL, 1'b1, 32'(p << 8));
            wb(OFS_TIM, 1'b1, 32'h0000_0003);
            send(16'h0100, 16'h0002, 1'b0);
            in_valid_i <= 1'b0;
            n = 0;
            do begin @(posedge clk_i); n++; end while (out_valid_o !== 1'b1 && n < 20);
            `CHK(n, 4)
            stall <= 1'b0;
            get(16'h0100, 16'h0002, 1'b0);
            stall <= 1'b1;
        end
    endtask
    // Back-to-back pairs alternate the select, then the full FIFO drains.
    task automatic t_fill;
        wb(OFS_CTRL, 1'b1, 32'(OP_SEL));
        for (int k = 0; k < FIFO_DEPTH; k++) send(16'(k * 16), 16'h0001, k[0]);
        in_valid_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        wb(OFS_STAT, 1'b0, '0);
        `CHK(rd[4:0], 5'h10)
        stall <= 1'b0;
        for (int k = 0; k < FIFO_DEPTH; k++) get(16'(k * 16), 16'h0001, k[0]);
        @(posedge clk_i);
        `CHK(out_valid_o, 1'b0)
    endtask
    // Unsigned user format at point zero: both carries legal, the sum wraps at 16 bits.
    task automatic t_carry;
        wb(OFS_CTRL, 1'b1, 32'h0000_0604);
        wb(OFS_FMT, 1'b1, 32'h0000_0200);
        in_data_i.carry_input <= 1'b1;
        send(16'hFFF0, 16'h0011, 1'b0);
        in_valid_i <= 1'b0;
        do @(posedge clk_i); while (!(out_valid_o === 1'b1 && rdy === 1'b1));
        for (int i = 0; i < LANES; i++) `CHK(out_data_o.sum[i], 17'(2 + i))
        `CHK(out_data_o.carry_output, 4'hF)
        wb(OFS_STAT, 1'b0, '0);
        `CHK(rd[STAT_OVF_BIT], 1'b1)
    endtask
    task automatic give_verdict;
        $display("errors %0d checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Cuts a hang short; the run needs well under a thousand cycles.
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            give_verdict;
        end
    end
    // Reset for four cycles, then the scenarios in turn.
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_regs;
        t_ops;
        t_lat;
        t_fill;
        t_carry;
        give_verdict;
    end
endmodule
